// ==== sdl_consts.vh ====
/*
  Constants for the serial converter shift and load logic.
  Assumes it is included by bare name from the design files.
*/
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH
`define SDL_WORD_W 12
`define SDL_WORD_MSB 11
`define SDL_CODE_ZERO 12'h000
`define SDL_SYNC_W 3
// Idle level of each synchronised pin: inverted strobe, both loads and clear rest high.
`define SDL_PIN_IDLE 8'h78
`define SDL_FIFO_DEPTH 16
`define SDL_FIFO_AW 4
`define SDL_BIT_CNT_ZERO 4'h0
`define SDL_BIT_CNT_LAST 4'hB
`endif

// ==== sdl_fifo.v ====
/*
  Parameterised first-in first-out buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "sdl_consts.vh"
module sdl_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset.
  input wire sys_clk,
  input wire reset,
  // Fill side.
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side.
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  wire empty;
  wire full;
  assign empty = (wrPtr_q == rdPtr_q);
  assign full = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[AW-1:0]];
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (inValid && !full)
      begin
        mem[wrPtr_q[AW-1:0]] <= inData;
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty)
        rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule // sdl_fifo

// ==== sdl_shift_load.v ====
/*
  Shift and load logic of a 12-bit serial-input converter with daisy-chain output.
  Assumes all strobe, load and clear pins are asynchronous to sys_clk and
  that strobes are slow (link period 160 ns) compared with the 20 ns clock.
*/
// Behaviour
// - A rising edge on any rising strobe shifts one bit in and advances the chain output.
// - A falling edge on the inverted strobe shifts one bit just like a rising strobe edge.
// - The chain output shows the bit that entered twelve shifts earlier.
// - A strobe held at its blocking level stops all shifting on the other strobes.
// - A bit shifts only when one strobe edges while the others sit at their idle levels.
// - Words travel most significant bit first both in and out.
// - Once a word is in, asserting both loads copies the input register to the code register.
// - Both loads are active low and copy only while both are low and clear is high.
// - With either load high and clear inactive the code register holds.
// - Clear low forces the code register to zero regardless of strobes.
// - Clear leaves the input register and the chain output alone.
// - Clear wins over loading.
`timescale 1ns/1ps
`include "sdl_consts.vh"
module sdl_shift_load (
  // Clock and reset.
  input wire sys_clk,
  input wire reset,
  // Strobe pins.
  input wire shift_strobe_rise_a,
  input wire shift_strobe_rise_b,
  input wire shift_strobe_rise_c,
  input wire shift_strobe_fall_n,
  // Serial data.
  input wire serial_word_in,
  output wire serial_chain_out,
  // Load and clear pins.
  input wire load_enable_a_n,
  input wire load_enable_b_n,
  input wire clear_code_n,
  // Code to the converter core.
  output wire [11:0] converterCode,
  // Stream of codes taken into the code register.
  output wire codeValid,
  input wire codeReady,
  output wire [11:0] codeData,
  output wire codeOverflow
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Each pin passes three flops; a change counts once stages two and three agree.
  wire [7:0] pinRaw;
  reg [7:0] pinS1_q;
  reg [7:0] pinS2_q;
  reg [7:0] pinS3_q;
  reg [7:0] pinLvl_q;
  reg [7:0] pinLvlPrev_q;
  assign pinRaw = {serial_word_in, clear_code_n, load_enable_b_n, load_enable_a_n,
                   shift_strobe_fall_n, shift_strobe_rise_c, shift_strobe_rise_b, shift_strobe_rise_a};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : gSync
      // Every stage starts at the pin's idle level, so releasing reset never fakes an edge or a clear.
      wire [7:0] pinIdle = `SDL_PIN_IDLE;
      always @(posedge sys_clk)
      begin
        if (reset)
        begin
          pinS1_q[gi] <= pinIdle[gi];
          pinS2_q[gi] <= pinIdle[gi];
          pinS3_q[gi] <= pinIdle[gi];
          pinLvl_q[gi] <= pinIdle[gi];
          pinLvlPrev_q[gi] <= pinIdle[gi];
        end
        else
        begin
          pinS1_q[gi] <= pinRaw[gi];
          pinS2_q[gi] <= pinS1_q[gi];
          pinS3_q[gi] <= pinS2_q[gi];
          if (pinS2_q[gi] == pinS3_q[gi])
            pinLvl_q[gi] <= pinS3_q[gi];
          pinLvlPrev_q[gi] <= pinLvl_q[gi];
        end
      end
    end
  endgenerate

  wire riseA = pinLvl_q[0];
  wire riseB = pinLvl_q[1];
  wire riseC = pinLvl_q[2];
  wire fallN = pinLvl_q[3];
  wire loadAn = pinLvl_q[4];
  wire loadBn = pinLvl_q[5];
  wire clearN = pinLvl_q[6];
  wire dataIn = pinLvl_q[7];

  // ==========================================================
  // Strobe qualification
  // ==========================================================
  // rising edges found, and the falling edge of the inverted strobe
  wire edgeA = riseA && !pinLvlPrev_q[0];
  wire edgeB = riseB && !pinLvlPrev_q[1];
  wire edgeC = riseC && !pinLvlPrev_q[2];
  wire edgeN = !fallN && pinLvlPrev_q[3];
  // others must idle before the edge
  wire shiftEn = (edgeA && !pinLvlPrev_q[1] && !pinLvlPrev_q[2] && pinLvlPrev_q[3] && !riseB && !riseC && fallN)
              || (edgeB && !pinLvlPrev_q[0] && !pinLvlPrev_q[2] && pinLvlPrev_q[3] && !riseA && !riseC && fallN)
              || (edgeC && !pinLvlPrev_q[0] && !pinLvlPrev_q[1] && pinLvlPrev_q[3] && !riseA && !riseB && fallN)
              || (edgeN && !pinLvlPrev_q[0] && !pinLvlPrev_q[1] && !pinLvlPrev_q[2] && !riseA && !riseB && !riseC);

  // ==========================================================
  // Input shift register
  // ==========================================================
  reg [11:0] shiftReg_q;
  reg [3:0] bitCnt_q;
  wire [11:0] shiftReg_d = {shiftReg_q[`SDL_WORD_MSB-1:0], dataIn};
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      shiftReg_q <= `SDL_CODE_ZERO;
      bitCnt_q <= `SDL_BIT_CNT_ZERO;
    end
    else if (shiftEn)
    begin
      shiftReg_q <= shiftReg_d;
      bitCnt_q <= (bitCnt_q == `SDL_BIT_CNT_LAST) ? `SDL_BIT_CNT_ZERO : bitCnt_q + 4'h1;
    end
  end
  assign serial_chain_out = shiftReg_q[`SDL_WORD_MSB];

  // ==========================================================
  // Code register and load stream
  // ==========================================================
  // Clear is sampled, so it acts within the synchroniser delay rather than instantly.
  reg [11:0] code_q;
  reg loadSeen_q;
  reg overflow_q;
  wire fifoInReady;
  wire loadNow = !loadAn && !loadBn && clearN;
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      code_q <= `SDL_CODE_ZERO;
      loadSeen_q <= 1'b0;
      overflow_q <= 1'b0;
    end
    else if (!clearN)
    begin
      code_q <= `SDL_CODE_ZERO;
      loadSeen_q <= 1'b0;
    end
    else if (loadNow)
    begin
      code_q <= shiftReg_q;
      loadSeen_q <= 1'b1;
      if (!loadSeen_q && !fifoInReady)
        overflow_q <= 1'b1;
    end
    else
      loadSeen_q <= 1'b0;
  end
  assign converterCode = code_q;
  assign codeOverflow = overflow_q;

  // One entry per load assertion; a full buffer drops the entry and flags overflow.
  sdl_fifo #(
    .WIDTH(`SDL_WORD_W),
    .DEPTH(`SDL_FIFO_DEPTH),
    .AW(`SDL_FIFO_AW)
  ) uFifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .inValid(loadNow && !loadSeen_q),
    .inReady(fifoInReady),
    .inData(shiftReg_q),
    .outValid(codeValid),
    .outReady(codeReady),
    .outData(codeData)
  );
endmodule // sdl_shift_load

// ==== sdl_monitor.sv ====
/* Checker of the shift and load block port behaviour.
   Assumes it is bound to sdl_shift_load by port name. */
`timescale 1ns/1ps
module sdl_monitor (
  // Clock, reset and pins.
  input wire sys_clk,
  input wire reset,
  input wire shift_strobe_rise_a,
  input wire shift_strobe_rise_b,
  input wire shift_strobe_rise_c,
  input wire shift_strobe_fall_n,
  input wire load_enable_a_n,
  input wire load_enable_b_n,
  input wire clear_code_n,
  // Observed outputs.
  input wire serial_chain_out,
  input wire [11:0] converterCode,
  input wire codeOverflow
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire stbIdle = !shift_strobe_rise_a && !shift_strobe_rise_b && !shift_strobe_rise_c && shift_strobe_fall_n;
  wire bothLoad = !load_enable_a_n && !load_enable_b_n && clear_code_n;
  a_clear_zeroes: assert property ($fell(clear_code_n) |-> ##[1:6] converterCode == 12'h000)
    else $error("code not cleared");
  a_clear_wins: assert property (!clear_code_n [*6] |-> converterCode == 12'h000)
    else $error("load beat clear");
  a_hold_a_high: assert property ((load_enable_a_n && clear_code_n) [*7] |-> $stable(converterCode))
    else $error("code moved with load a high");
  a_hold_b_high: assert property ((load_enable_b_n && clear_code_n) [*7] |-> $stable(converterCode))
    else $error("code moved with load b high");
  a_idle_no_shift: assert property (stbIdle [*8] |-> $stable(serial_chain_out))
    else $error("shift without edge");
  a_block_high: assert property (shift_strobe_rise_b [*8] |-> $stable(serial_chain_out))
    else $error("shift while blocked high");
  a_block_low: assert property (!shift_strobe_fall_n [*8] |-> $stable(serial_chain_out))
    else $error("shift while blocked low");
  a_load_copies: assert property ((bothLoad && stbIdle) [*7] |-> converterCode[11] == serial_chain_out)
    else $error("load did not copy");
  cover property (bothLoad [*7]);
  cover property ($rose(codeOverflow));
  cover property ($fell(clear_code_n));
endmodule // sdl_monitor

// ==== sdl_host_model.sv ====
/* Host model driving strobe, data, load and clear pins.
   Assumes tasks are called just after a rising sys_clk edge. */
`timescale 1ns/1ps
module sdl_host_model (
  // Clock.
  input wire sys_clk,
  // Pins toward the device, idle at start.
  output reg shift_strobe_rise_a = 1'b0,
  output reg shift_strobe_rise_b = 1'b0,
  output reg shift_strobe_rise_c = 1'b0,
  output reg shift_strobe_fall_n = 1'b1,
  output reg serial_word_in = 1'b0,
  output reg load_enable_a_n = 1'b1,
  output reg load_enable_b_n = 1'b1,
  output reg clear_code_n = 1'b1
);
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic set_strobe(input int sel, input logic on);
    case (sel)
      0: shift_strobe_rise_a = on;
      1: shift_strobe_rise_b = on;
      2: shift_strobe_fall_n = !on;
      default: shift_strobe_rise_c = on;
    endcase
  endtask
  // one 160 ns bit.
  // Data is inverted once its hold has run out, so a late sample shows up.
  task automatic shift_bit(input logic b, input int sel, input logic hold);
    serial_word_in = b;
    tick(1);
    set_strobe(sel, 1'b1);
    tick(4);
    if (!hold)
      set_strobe(sel, 1'b0);
    tick(1);
    serial_word_in = !b;
    tick(2);
  endtask
  task automatic drive_ctl(input logic la, input logic lb, input logic clr, input int n);
    load_enable_a_n = la;
    load_enable_b_n = lb;
    clear_code_n = clr;
    tick(n);
  endtask
endmodule // sdl_host_model

// ==== testbench.sv ====
/* Top bench: device, host model and checker.
   Assumes a 50 MHz clock and twelve reset cycles. */
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic codeReady = 1'b0;
  wire shift_strobe_rise_a, shift_strobe_rise_b, shift_strobe_rise_c, shift_strobe_fall_n;
  wire serial_word_in, serial_chain_out, load_enable_a_n, load_enable_b_n, clear_code_n;
  wire codeValid, codeOverflow;
  wire [11:0] converterCode, codeData;
  int nFail = 0;
  int nCompared = 0;
  int cycles = 0;
  sdl_shift_load dut (.*);
  sdl_host_model host (.*);
  always #10 sys_clk = ~sys_clk;
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tallyAndFinish;
    $display("compared %0d mismatched %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic testLoad;
    for (int i = 11; i >= 0; i--)
      host.shift_bit(12'hA5C >> i, 0, 1'b0);
    host.drive_ctl(1'b0, 1'b1, 1'b1, 8);
    check(converterCode, 12'h000);
    host.drive_ctl(1'b0, 1'b0, 1'b1, 8);
    check(converterCode, 12'hA5C);
    check(codeData, 12'hA5C);
    codeReady = 1'b1;
    host.drive_ctl(1'b1, 1'b1, 1'b1, 2);
    check({11'h000, codeValid}, 12'h000);
  endtask
  task automatic testChain;
    for (int i = 11; i >= 0; i--)
    begin
      check({11'h000, serial_chain_out}, 12'hA5C >> i & 12'h001);
      host.shift_bit(12'h3C6 >> i, i % 4, 1'b0);
    end
    host.drive_ctl(1'b0, 1'b0, 1'b1, 8);
    check(converterCode, 12'h3C6);
    host.drive_ctl(1'b1, 1'b1, 1'b1, 8);
  endtask
  // The blocking strobe's own rising edge shifts one bit before it blocks.
  task automatic testBlock;
    host.shift_bit(1'b1, 1, 1'b1);
    host.shift_bit(1'b0, 0, 1'b0);
    host.shift_bit(1'b0, 2, 1'b0);
    host.set_strobe(1, 1'b0);
    host.drive_ctl(1'b0, 1'b0, 1'b1, 8);
    check(converterCode, 12'h78D);
    host.drive_ctl(1'b1, 1'b1, 1'b1, 8);
  endtask
  task automatic testClear;
    host.drive_ctl(1'b0, 1'b0, 1'b0, 8);
    check(converterCode, 12'h000);
    host.drive_ctl(1'b1, 1'b1, 1'b1, 8);
    check(converterCode, 12'h000);
    check({11'h000, serial_chain_out}, 12'h000);
    host.drive_ctl(1'b0, 1'b0, 1'b1, 8);
    check(converterCode, 12'h78D);
    host.drive_ctl(1'b1, 1'b1, 1'b0, 8);
    check(converterCode, 12'h000);
    host.drive_ctl(1'b1, 1'b1, 1'b1, 8);
  endtask
  task automatic testFifo;
    codeReady = 1'b0;
    repeat (17)
    begin
      host.drive_ctl(1'b0, 1'b0, 1'b1, 6);
      host.drive_ctl(1'b1, 1'b1, 1'b1, 6);
    end
    check({11'h000, codeOverflow}, 12'h001);
    check(codeData, 12'h78D);
    codeReady = 1'b1;
    host.tick(17);
    check({11'h000, codeValid}, 12'h000);
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      nFail++;
      tallyAndFinish;
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    testLoad;
    testChain;
    testBlock;
    testClear;
    testFifo;
    tallyAndFinish;
  end
endmodule // testbench
bind sdl_shift_load sdl_monitor mon (.*);
